// [rtl/cim_irq_mask.sv]
// card interface interrupt mask block with an ahb-lite register slave
//
// Functional notes
// - enable-set write ones set mask bits
// - enable-clear write ones clear mask bits
// - mask read shows enabled sources as ones
// - bits 0..7 are command through tx-end
// - bits 8,9 card irqs; 14,15 buffers
// - bits 16..22 response and data errors
// - bit 30 overrun, bit 31 underrun
//
// Decided for this implementation: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/100ps
module cim_irq_mask
  import cim_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // status flags of the card interface logic
  input  wire cim_src_t    status_flags,
  // interrupt request
  output logic             irq
);

  // declarations, grouped by the path that uses them
  // bus phase state and captured request
  cim_state_t       state_q;
  cim_state_t       state_d;
  cim_xfer_t        xfer_q;
  cim_xfer_t        xfer_d;

  // registered bus and interrupt outputs
  logic             hreadyout_q;
  logic             hreadyout_d;
  logic             hresp_q;
  logic [31:0]      hrdata_q;
  logic [31:0]      hrdata_d;
  logic             irq_q;
  logic             irq_d;

  // sampled flags, mask and sticky events
  logic [31:0]      flags_q;
  logic [31:0]      flags_d;
  logic [31:0]      mask_q;
  logic [31:0]      events_q;
  cim_src_t         flags_src;

  // transfer qualifiers
  logic             accept;
  logic             accept_wr;
  logic             accept_rd;
  logic             wr_phase;
  logic             rd_load;

  // register decode and write strobes
  logic             hit_set;
  logic             hit_clear;
  logic             hit_state;
  logic             hit_events;
  logic             hit_raw;
  logic             hit_pending;
  logic             wr_set;
  logic             wr_clear;
  logic             wr_events;

  // strobe words into the bit registers
  cim_src_t         wdata_src;
  logic [31:0]      wdata_valid;
  logic [31:0]      mask_set;
  logic [31:0]      mask_clr;
  logic [31:0]      ev_set;
  logic [31:0]      ev_clr;

  // interrupt and read paths
  logic [31:0]      pending;
  logic [31:0]      rdata;
  logic [31:0]      rd_state;
  logic [31:0]      rd_events;
  logic [31:0]      rd_raw;
  logic [31:0]      rd_pending;

  // bus address phase
  // a request is only taken at an edge where ready is high

  // a transfer is taken only when selected, nonseq and the bus is ready;
  // only whole-word singles are expected, so hsize is not decoded
  assign accept    = hsel & (htrans == CIM_HTRANS_NONSEQ) & hready;
  assign accept_wr = accept & hwrite;
  assign accept_rd = accept & ~hwrite;

  // captured request for the data phase
  // hsize is not kept: subword accesses act as whole words
  assign xfer_d.write = hwrite;
  assign xfer_d.addr  = haddr[CIM_ADDR_W-1:0];

  // data phase qualifiers
  assign wr_phase = (state_q == CIM_ST_WRITE);
  assign rd_load  = (state_q == CIM_ST_RDWT);

  // slave phase sequencing
  // one small state machine owns ready, so no path can stall the bus twice

  // reads take one wait state so a write just before is already visible;
  // writes complete with zero wait states and may be followed back to back
  always_comb begin
    state_d     = state_q;
    hreadyout_d = hreadyout_q;
    unique case (state_q)
      // new transfers are taken in any phase where ready is high
      CIM_ST_IDLE, CIM_ST_WRITE, CIM_ST_RDOUT: begin
        if (accept_rd) begin
          state_d     = CIM_ST_RDWT;
          hreadyout_d = 1'b0;
        end else if (accept_wr) begin
          state_d     = CIM_ST_WRITE;
          hreadyout_d = 1'b1;
        end else begin
          state_d     = CIM_ST_IDLE;
          hreadyout_d = 1'b1;
        end
      end
      // wait state over: read data is loaded in this cycle
      CIM_ST_RDWT: begin
        state_d     = CIM_ST_RDOUT;
        hreadyout_d = 1'b1;
      end
    endcase
  end

  // phase state, ready and captured address
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q     <= CIM_ST_IDLE;
      hreadyout_q <= 1'b1;
      xfer_q      <= '0;
    end else begin
      state_q     <= state_d;
      hreadyout_q <= hreadyout_d;
      if (accept) begin
        xfer_q <= xfer_d;
      end
    end
  end

  // the slave never signals an error, not even for unmapped offsets
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hresp_q <= CIM_HRESP_OKAY;
    end else begin
      hresp_q <= CIM_HRESP_OKAY;
    end
  end

  // address decode
  // compared against the captured address, never the live bus

  // one word per register; anything else hits nothing
  assign hit_set     = (xfer_q.addr == CIM_OFF_ENABLE_SET);
  assign hit_clear   = (xfer_q.addr == CIM_OFF_ENABLE_CLEAR);
  assign hit_state   = (xfer_q.addr == CIM_OFF_ENABLE_STATE);
  assign hit_events  = (xfer_q.addr == CIM_OFF_EVENT_STATUS);
  assign hit_raw     = (xfer_q.addr == CIM_OFF_RAW_FLAGS);
  assign hit_pending = (xfer_q.addr == CIM_OFF_PENDING);

  // write strobes, valid in the write data phase only
  assign wr_set    = wr_phase & hit_set;
  assign wr_clear  = wr_phase & hit_clear;
  assign wr_events = wr_phase & hit_events;

  // write data placed field by field from the source bit positions;
  // a layout slip shows up here rather than in every register
  // command through transmit-end sources
  assign wdata_src.command_done         = hwdata[CIM_BIT_COMMAND_DONE];
  assign wdata_src.rx_word_ready        = hwdata[CIM_BIT_RX_WORD_READY];
  assign wdata_src.tx_word_taken        = hwdata[CIM_BIT_TX_WORD_TAKEN];
  assign wdata_src.block_ended          = hwdata[CIM_BIT_BLOCK_ENDED];
  assign wdata_src.transfer_in_progress = hwdata[CIM_BIT_TRANSFER_IN_PROGRESS];
  assign wdata_src.card_free            = hwdata[CIM_BIT_CARD_FREE];
  assign wdata_src.rx_count_end         = hwdata[CIM_BIT_RX_COUNT_END];
  assign wdata_src.tx_count_end         = hwdata[CIM_BIT_TX_COUNT_END];
  assign wdata_src.card_a_irq           = hwdata[CIM_BIT_CARD_A_IRQ];
  assign wdata_src.card_b_irq           = hwdata[CIM_BIT_CARD_B_IRQ];
  assign wdata_src.rx_buffers_full      = hwdata[CIM_BIT_RX_BUFFERS_FULL];
  assign wdata_src.tx_buffers_empty     = hwdata[CIM_BIT_TX_BUFFERS_EMPTY];
  assign wdata_src.resp_index_err       = hwdata[CIM_BIT_RESP_INDEX_ERR];
  assign wdata_src.resp_direction_err   = hwdata[CIM_BIT_RESP_DIRECTION_ERR];
  assign wdata_src.resp_crc_err         = hwdata[CIM_BIT_RESP_CRC_ERR];
  assign wdata_src.resp_endbit_err      = hwdata[CIM_BIT_RESP_ENDBIT_ERR];
  assign wdata_src.resp_timeout_err     = hwdata[CIM_BIT_RESP_TIMEOUT_ERR];
  assign wdata_src.data_crc_err         = hwdata[CIM_BIT_DATA_CRC_ERR];
  assign wdata_src.data_timeout_err     = hwdata[CIM_BIT_DATA_TIMEOUT_ERR];
  assign wdata_src.rx_overrun           = hwdata[CIM_BIT_RX_OVERRUN];
  assign wdata_src.tx_underrun          = hwdata[CIM_BIT_TX_UNDERRUN];
  assign wdata_src.unused_13_10         = 4'h0;
  assign wdata_src.unused_29_23         = 7'h00;
  assign wdata_valid                    = wdata_src;

  // interrupt mask
  // writes reach the mask only in the data phase of a write

  assign mask_set = wr_set ? wdata_valid : '0;
  assign mask_clr = wr_clear ? wdata_valid : '0;

  cim_bitreg #(
    .WIDTH    (32),
    .RST_VAL  (CIM_RST_MASK),
    .KEEP     (CIM_SRC_VALID),
    .SET_WINS (1'b1)
  ) u_mask (
    .clk      (clk),
    .rstn     (rstn),
    .set_bits (mask_set),
    .clr_bits (mask_clr),
    .value_q  (mask_q)
  );

  // status flag capture and sticky events
  // events remember a flag that was too short for software to see

  // status flags taken field by field so the irq path sees the same layout
  // command through transmit-end flags
  assign flags_src.command_done         = status_flags.command_done;
  assign flags_src.rx_word_ready        = status_flags.rx_word_ready;
  assign flags_src.tx_word_taken        = status_flags.tx_word_taken;
  assign flags_src.block_ended          = status_flags.block_ended;
  assign flags_src.transfer_in_progress = status_flags.transfer_in_progress;
  assign flags_src.card_free            = status_flags.card_free;
  assign flags_src.rx_count_end         = status_flags.rx_count_end;
  assign flags_src.tx_count_end         = status_flags.tx_count_end;
  assign flags_src.card_a_irq           = status_flags.card_a_irq;
  assign flags_src.card_b_irq           = status_flags.card_b_irq;
  assign flags_src.rx_buffers_full      = status_flags.rx_buffers_full;
  assign flags_src.tx_buffers_empty     = status_flags.tx_buffers_empty;
  assign flags_src.resp_index_err       = status_flags.resp_index_err;
  assign flags_src.resp_direction_err   = status_flags.resp_direction_err;
  assign flags_src.resp_crc_err         = status_flags.resp_crc_err;
  assign flags_src.resp_endbit_err      = status_flags.resp_endbit_err;
  assign flags_src.resp_timeout_err     = status_flags.resp_timeout_err;
  assign flags_src.data_crc_err         = status_flags.data_crc_err;
  assign flags_src.data_timeout_err     = status_flags.data_timeout_err;
  assign flags_src.rx_overrun           = status_flags.rx_overrun;
  assign flags_src.tx_underrun          = status_flags.tx_underrun;
  // unassigned flag positions never raise irq
  assign flags_src.unused_13_10         = 4'h0;
  assign flags_src.unused_29_23         = 7'h00;
  assign flags_d                        = flags_src;

  // flags are synchronous to clk; one register stage keeps irq timing fixed
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      flags_q <= '0;
    end else begin
      flags_q <= flags_d;
    end
  end

  // a flag that is high latches its event bit; write one clears it,
  // but a flag still high in that cycle keeps the bit set
  assign ev_set = flags_q;
  assign ev_clr = wr_events ? wdata_valid : '0;

  cim_bitreg #(
    .WIDTH    (32),
    .RST_VAL  (CIM_RST_EVENTS),
    .KEEP     (CIM_SRC_VALID),
    .SET_WINS (1'b1)
  ) u_events (
    .clk      (clk),
    .rstn     (rstn),
    .set_bits (ev_set),
    .clr_bits (ev_clr),
    .value_q  (events_q)
  );

  // interrupt output
  // level output: software clears the cause, not the line

  // sticky events keep irq up after a flag drops until software clears them
  // flag or sticky event, gated by the mask, drives irq
  assign pending = (flags_q | events_q) & mask_q;
  assign irq_d   = |pending;

  // registered so the pin never glitches on decode
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= irq_d;
    end
  end

  // read data
  // one mux of decoded words, loaded only in the read wait cycle

  assign rd_state   = hit_state ? mask_q : '0;
  // event, raw and pending words give software extra visibility
  assign rd_events  = hit_events ? events_q : '0;
  assign rd_raw     = hit_raw ? flags_q : '0;
  assign rd_pending = hit_pending ? pending : '0;

  // write-only registers and unmapped offsets read as zero
  // unassigned bits read zero
  assign rdata = (rd_state | rd_events | rd_raw | rd_pending) & CIM_SRC_VALID;

  // read data loaded in the wait cycle, held until the next read
  assign hrdata_d = rd_load ? rdata : hrdata_q;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hrdata_q <= CIM_RST_RDATA;
    end else begin
      hrdata_q <= hrdata_d;
    end
  end

  // outputs, each straight from a flip-flop
  // no logic sits between these registers and the pins
  assign hreadyout = hreadyout_q;
  assign hresp     = hresp_q;
  assign hrdata    = hrdata_q;
  assign irq       = irq_q;

endmodule : cim_irq_mask

// [rtl/cim_pkg.sv]
// package with register map, source bit layout and bus constants of the card interrupt mask
package cim_pkg;

  // register byte offsets, one aligned 32-bit word each
  localparam logic [7:0] CIM_OFF_ENABLE_SET   = 8'h00;
  localparam logic [7:0] CIM_OFF_ENABLE_CLEAR = 8'h04;
  localparam logic [7:0] CIM_OFF_ENABLE_STATE = 8'h08;
  localparam logic [7:0] CIM_OFF_EVENT_STATUS = 8'h0c;
  localparam logic [7:0] CIM_OFF_RAW_FLAGS    = 8'h10;
  localparam logic [7:0] CIM_OFF_PENDING      = 8'h14;

  // number of address bits decoded by the slave
  localparam int unsigned CIM_ADDR_W = 8;

  // bit positions of the interrupt sources, same in every register
  localparam int unsigned CIM_BIT_COMMAND_DONE         = 0;
  localparam int unsigned CIM_BIT_RX_WORD_READY        = 1;
  localparam int unsigned CIM_BIT_TX_WORD_TAKEN        = 2;
  localparam int unsigned CIM_BIT_BLOCK_ENDED          = 3;
  localparam int unsigned CIM_BIT_TRANSFER_IN_PROGRESS = 4;
  localparam int unsigned CIM_BIT_CARD_FREE            = 5;
  localparam int unsigned CIM_BIT_RX_COUNT_END         = 6;
  localparam int unsigned CIM_BIT_TX_COUNT_END         = 7;
  localparam int unsigned CIM_BIT_CARD_A_IRQ           = 8;
  localparam int unsigned CIM_BIT_CARD_B_IRQ           = 9;
  localparam int unsigned CIM_BIT_RX_BUFFERS_FULL      = 14;
  localparam int unsigned CIM_BIT_TX_BUFFERS_EMPTY     = 15;
  localparam int unsigned CIM_BIT_RESP_INDEX_ERR       = 16;
  localparam int unsigned CIM_BIT_RESP_DIRECTION_ERR   = 17;
  localparam int unsigned CIM_BIT_RESP_CRC_ERR         = 18;
  localparam int unsigned CIM_BIT_RESP_ENDBIT_ERR      = 19;
  localparam int unsigned CIM_BIT_RESP_TIMEOUT_ERR     = 20;
  localparam int unsigned CIM_BIT_DATA_CRC_ERR         = 21;
  localparam int unsigned CIM_BIT_DATA_TIMEOUT_ERR     = 22;
  localparam int unsigned CIM_BIT_RX_OVERRUN           = 30;
  localparam int unsigned CIM_BIT_TX_UNDERRUN          = 31;

  // assigned source positions; all others read zero and ignore writes
  localparam logic [31:0] CIM_SRC_VALID = 32'hc07fc3ff;

  // values after reset
  localparam logic [31:0] CIM_RST_MASK   = 32'h0000_0000;
  localparam logic [31:0] CIM_RST_EVENTS = 32'h0000_0000;
  localparam logic [31:0] CIM_RST_RDATA  = 32'h0000_0000;

  // ahb encodings used by the slave
  localparam logic [1:0] CIM_HTRANS_NONSEQ = 2'b10;
  localparam logic       CIM_HRESP_OKAY    = 1'b0;

  // source vector, msb first, matching the status register layout
  typedef struct packed {
    logic       tx_underrun;
    logic       rx_overrun;
    logic [6:0] unused_29_23;
    logic       data_timeout_err;
    logic       data_crc_err;
    logic       resp_timeout_err;
    logic       resp_endbit_err;
    logic       resp_crc_err;
    logic       resp_direction_err;
    logic       resp_index_err;
    logic       tx_buffers_empty;
    logic       rx_buffers_full;
    logic [3:0] unused_13_10;
    logic       card_b_irq;
    logic       card_a_irq;
    logic       tx_count_end;
    logic       rx_count_end;
    logic       card_free;
    logic       transfer_in_progress;
    logic       block_ended;
    logic       tx_word_taken;
    logic       rx_word_ready;
    logic       command_done;
  } cim_src_t;

  // captured address phase of one ahb transfer
  typedef struct packed {
    logic                  write;
    logic [CIM_ADDR_W-1:0] addr;
  } cim_xfer_t;

  // bus slave phase
  typedef enum logic [1:0] {
    CIM_ST_IDLE  = 2'b00,
    CIM_ST_WRITE = 2'b01,
    CIM_ST_RDWT  = 2'b10,
    CIM_ST_RDOUT = 2'b11
  } cim_state_t;

endpackage : cim_pkg

// [rtl/cim_bitreg.sv]
// set/clear bit register with per-bit strobes and selectable set priority
`timescale 1ns/100ps
module cim_bitreg
  import cim_pkg::*;
#(
  parameter int unsigned       WIDTH    = 32,
  parameter logic [WIDTH-1:0]  RST_VAL  = '0,
  parameter logic [WIDTH-1:0]  KEEP     = '1,
  parameter bit                SET_WINS = 1'b1
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rstn,
  // per-bit strobes
  input  wire logic [WIDTH-1:0] set_bits,
  input  wire logic [WIDTH-1:0] clr_bits,
  // stored value
  output logic      [WIDTH-1:0] value_q
);

  logic [WIDTH-1:0] value_d;
  logic [WIDTH-1:0] set_win;
  logic [WIDTH-1:0] clr_win;

  // strobe priority: a set arriving with a clear is not lost unless told otherwise
  assign set_win = SET_WINS ? set_bits : (set_bits & ~clr_bits);
  assign clr_win = SET_WINS ? (clr_bits & ~set_bits) : clr_bits;
  // positions outside KEEP never hold a one
  assign value_d = ((value_q | set_win) & ~clr_win) & KEEP;

  // storage
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      value_q <= RST_VAL;
    end else begin
      value_q <= value_d;
    end
  end

endmodule : cim_bitreg

// [bench/cim_irq_mask_assertions.sv]
// concurrent checks of the card interrupt mask, seen from its ports
`timescale 1ns/100ps
module cim_irq_mask_assertions
  import cim_pkg::*;
(
  // clock and reset
  input wire logic        clk,
  input wire logic        rstn,
  // register bus
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  // flags and request
  input wire cim_src_t    status_flags,
  input wire logic        irq
);
  logic        dp_q;
  logic        wr_q;
  logic [7:0]  ad_q;
  logic [31:0] sh_q;
  logic [31:0] sh_d;

  // transfer tracking; only the low address byte is decoded
  wire take     = hsel && htrans == CIM_HTRANS_NONSEQ && hready;
  wire wdone    = dp_q && wr_q && hready;
  wire rd_state = dp_q && !wr_q && hready && ad_q == CIM_OFF_ENABLE_STATE;

  // shadow of the mask, moved at the edge that ends a write data phase
  assign sh_d = !wdone ? sh_q :
                ad_q == CIM_OFF_ENABLE_SET ? sh_q | (hwdata & CIM_SRC_VALID) :
                ad_q == CIM_OFF_ENABLE_CLEAR ? sh_q & ~hwdata : sh_q;

  // phase and shadow registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dp_q <= 1'b0;
      wr_q <= 1'b0;
      ad_q <= 8'h00;
      sh_q <= CIM_RST_MASK;
    end else begin
      if (take || hready) dp_q <= take;
      if (take) wr_q <= hwrite;
      if (take) ad_q <= haddr[7:0];
      sh_q <= sh_d;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  // flag seen with mask set, then still set when the sample reaches irq
  sequence s_hit(logic [31:0] g);
    |(status_flags & sh_q & g) ##1 |($past(status_flags) & sh_q & g);
  endsequence

  AST_SET_KEPT: assert property (rd_state |-> (hrdata & sh_q) == sh_q)
    else $error("enabled source lost from mask");
  AST_CLR_GONE: assert property (rd_state |-> (hrdata & ~sh_q) == 32'h0)
    else $error("disabled source still in mask");
  AST_STATE_READ: assert property (rd_state |-> hrdata == sh_q)
    else $error("mask read differs from enabled set");
  AST_HIT_LOW: assert property (s_hit(32'h0000_00ff) |=> irq)
    else $error("irq missing for bits 7 to 0");
  AST_HIT_CARD: assert property (s_hit(32'h0000_c300) |=> irq)
    else $error("irq missing for card or buffer bits");
  AST_HIT_ERR: assert property (s_hit(32'h007f_0000) |=> irq)
    else $error("irq missing for error bits");
  AST_HIT_RUN: assert property (s_hit(32'hc000_0000) |=> irq)
    else $error("irq missing for overrun or underrun");
  AST_SPARE_ZERO: assert property (rd_state |-> (hrdata & ~CIM_SRC_VALID) == 32'h0)
    else $error("unassigned mask bit reads one");
  AST_MASK_OFF: assert property (sh_q == 32'h0 |=> !irq)
    else $error("irq high with every source disabled");
endmodule : cim_irq_mask_assertions

bind cim_irq_mask cim_irq_mask_assertions i_chk (
  .clk, .rstn, .hsel, .haddr, .htrans, .hwrite, .hwdata,
  .hready, .hrdata, .status_flags, .irq
);

// [bench/cim_irq_mask_tb.sv]
// self-checking bench of the card interrupt mask
`timescale 1ns/100ps
module cim_irq_mask_tb
  import cim_pkg::*;
;
  logic        clk          = 1'b0;
  logic        rstn         = 1'b0;
  logic        hsel         = 1'b0;
  logic        hwrite       = 1'b0;
  logic [1:0]  htrans       = 2'b00;
  logic [2:0]  hsize        = 3'h2;
  logic [31:0] haddr        = 32'h0;
  logic [31:0] hwdata       = 32'h0;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        irq;
  cim_src_t    status_flags = '0;
  logic [31:0] mdl;
  logic [31:0] rd;
  logic [31:0] d;
  logic [31:0] seed         = 32'h0000_9100;
  int          err_total    = 0;
  int          comparisons  = 0;

  // 100 MHz clock
  always #5 clk = ~clk;

  // single slave: its ready is the bus ready
  cim_irq_mask i_dut (
    .clk, .rstn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .status_flags, .irq
  );

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  // expected mask after a set or clear write
  function automatic logic [31:0] nxt(input logic [31:0] m, input logic c,
                                      input logic [31:0] v);
    return c ? (m & ~v) : (m | (v & CIM_SRC_VALID));
  endfunction : nxt

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : check

  // wait for hready high at a rising edge; only the watchdog ends a hang
  task automatic wait_rdy();
    do begin
      @(posedge clk);
    end while (hreadyout !== 1'b1);
  endtask : wait_rdy

  // one word transfer, entered right after an edge so calls run back to back
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] v);
    hsel <= 1'b1;
    htrans <= CIM_HTRANS_NONSEQ;
    haddr <= {24'h0, a};
    hwrite <= w;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= v;
    wait_rdy();
    rd = hrdata;
    check({31'h0, hresp}, {31'h0, CIM_HRESP_OKAY});
  endtask : xfer

  // raise flags, look at every path they reach, drop them and wipe the events
  task automatic pulse(input logic [31:0] f);
    logic [31:0] e;
    e = f & CIM_SRC_VALID;
    status_flags <= f;
    repeat (4) @(posedge clk);
    check({31'h0, irq}, {31'h0, |(e & mdl)});
    xfer(CIM_OFF_RAW_FLAGS, 1'b0, 32'h0);
    check(rd, e);
    xfer(CIM_OFF_PENDING, 1'b0, 32'h0);
    check(rd, e & mdl);
    status_flags <= '0;
    repeat (2) @(posedge clk);
    xfer(CIM_OFF_EVENT_STATUS, 1'b0, 32'h0);
    check(rd, e);
    check({31'h0, irq}, {31'h0, |(e & mdl)});
    xfer(CIM_OFF_EVENT_STATUS, 1'b1, 32'hffff_ffff);
    repeat (2) @(posedge clk);
    check({31'h0, irq}, 32'h0);
  endtask : pulse

  task automatic complete_run();
    $display("counts: %0d comparisons, %0d mismatches", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : complete_run

  // main sequence
  initial begin
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    mdl = CIM_RST_MASK;
    xfer(CIM_OFF_ENABLE_STATE, 1'b1, 32'hffff_ffff);
    xfer(CIM_OFF_ENABLE_STATE, 1'b0, 32'h0);
    check(rd, mdl);
    xfer(8'h3c, 1'b0, 32'h0);
    check(rd, 32'h0);
    xfer(CIM_OFF_ENABLE_SET, 1'b1, 32'hffff_ffff);
    mdl = nxt(mdl, 1'b0, 32'hffff_ffff);
    xfer(CIM_OFF_ENABLE_STATE, 1'b0, 32'h0);
    check(rd, mdl);
    xfer(CIM_OFF_ENABLE_CLEAR, 1'b1, 32'hffff_ffff);
    mdl = 32'h0;
    $display("test reset and refused places done");
    // every position alone, assigned or spare
    for (int i = 0; i < 32; i++) begin
      xfer(CIM_OFF_ENABLE_SET, 1'b1, 32'h1 << i);
      mdl = nxt(mdl, 1'b0, 32'h1 << i);
      xfer(CIM_OFF_ENABLE_STATE, 1'b0, 32'h0);
      check(rd, mdl);
      pulse(32'h1 << i);
      xfer(CIM_OFF_ENABLE_CLEAR, 1'b1, 32'h1 << i);
      mdl = nxt(mdl, 1'b1, 32'h1 << i);
      xfer(CIM_OFF_ENABLE_STATE, 1'b0, 32'h0);
      check(rd, mdl);
      pulse(32'h1 << i);
    end
    $display("test bit walk done");
    // random set and clear words with random flag patterns
    for (int k = 0; k < 40; k++) begin
      d = xs();
      xfer(seed[3] ? CIM_OFF_ENABLE_CLEAR : CIM_OFF_ENABLE_SET, 1'b1, d);
      mdl = nxt(mdl, seed[3], d);
      xfer(CIM_OFF_ENABLE_STATE, 1'b0, 32'h0);
      check(rd, mdl);
      pulse(xs() & xs() & xs());
    end
    $display("test random traffic done");
    complete_run();
  end

  // the sequence needs about 2500 cycles; cut a hang well beyond that
  initial begin
    #100000;
    err_total++;
    complete_run();
  end
endmodule : cim_irq_mask_tb
